/* File: dv/gcij_top_sva.sv */
`timescale 1ns/10ps
`include "gcij_regs.vh"
// ----
// Port checks
// ----
module gcij_chk (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Issue side
    input wire [4:0] issue,
    input wire [4:0] guarded,
    input wire [4:0] guard_lsb,
    input wire [39:0] opcode,
    input wire [34:0] imm7,
    input wire [159:0] imm32,
    input wire [159:0] first_source,
    input wire [159:0] second_source,
    input wire exception_pending,
    // Results
    input wire [4:0] wr_en,
    input wire [159:0] wr_data,
    input wire pc_load,
    input wire service_exception,
    input wire service_interrupt,
    input wire [31:0] current_program_counter,
    input wire [31:0] destination_program_counter,
    input wire [31:0] restart_program_counter
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Reference outcomes; only slot 4 jumps are judged so slot priority cannot blur them.
    wire gt_i = $signed(first_source[31:0]) > $signed(imm7[6:0]);
    wire gt_r = $signed(first_source[127:96]) > $signed(second_source[127:96]);
    wire j4 = issue[3] && opcode[31:24] == `GCIJ_OP_JMP_FALSE && issue[2:1] == 2'h0;
    wire go4 = (!guarded[3] || guard_lsb[3]) && !first_source[96];
    wire redir = pc_load || service_exception || service_interrupt;
    gt_imm_a: assert property (issue[0] && opcode[7:0] == `GCIJ_OP_GTR_IMM && guard_lsb[0]
        |=> wr_en[0] && wr_data[31:0] == {31'h0, $past(gt_i)}) else $error("gt imm");
    gt_reg_a: assert property (issue[3] && opcode[31:24] == `GCIJ_OP_GTR && guard_lsb[3]
        |=> wr_en[3] && wr_data[127:96] == {31'h0, $past(gt_r)}) else $error("gt reg");
    imm_load_a: assert property (issue[1] && opcode[15:8] == `GCIJ_OP_IMM
        |=> wr_en[1] && wr_data[63:32] == $past(imm32[63:32])) else $error("imm");
    guard_off_a: assert property (issue[0] && guarded[0] && !guard_lsb[0] && opcode[7:0] != `GCIJ_OP_IMM
        |=> !wr_en[0]) else $error("guard");
    jump_land_a: assert property (j4 && go4
        |-> ##4 redir && destination_program_counter == $past(second_source[127:96], 4)) else $error("land");
    jump_skip_a: assert property (j4 && !go4 |-> ##4 !redir) else $error("skip");
    pc_copy_a: assert property (pc_load |-> current_program_counter == destination_program_counter
        && restart_program_counter == destination_program_counter) else $error("copy");
    svc_prio_a: assert property (service_interrupt
        |-> !service_exception && !pc_load && !$past(exception_pending)) else $error("prio");
endmodule
bind gcij_top gcij_chk chk (.clk, .rst, .issue, .guarded, .guard_lsb, .opcode, .imm7, .imm32, .first_source,
    .second_source, .exception_pending, .wr_en, .wr_data, .pc_load, .service_exception, .service_interrupt,
    .current_program_counter, .destination_program_counter, .restart_program_counter);

/* File: dv/tb_guarded_compare_imm_jump_ops.sv */
`timescale 1ns/10ps
`include "gcij_regs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; $display("BAD %0t mismatch", $time); end end
module tb_guarded_compare_imm_jump_ops;
    reg clk = 0, rst = 1, exception_pending = 0, interrupt_pending = 0;
    reg [4:0] issue = 0, guarded = 0, guard_lsb = 0;
    reg [39:0] opcode = 0;
    reg [34:0] imm7 = 0, dest_in = 0;
    reg [159:0] imm32 = 0, first_source = 0, second_source = 0;
    wire [4:0] wr_en;
    wire [34:0] wr_dest;
    wire [159:0] wr_data;
    wire pc_load, service_exception, service_interrupt;
    wire [31:0] current_program_counter, destination_program_counter, restart_program_counter;
    integer failures = 0, tests_run = 0;
    reg [31:0] exp_pc = 0, exp_dpc = 0;
    gcij_top uut (.clk, .rst, .issue, .opcode, .imm7, .imm32, .guarded, .guard_lsb, .first_source,
        .second_source, .dest_in, .exception_pending, .interrupt_pending, .wr_en, .wr_dest, .wr_data,
        .pc_load, .current_program_counter, .destination_program_counter, .restart_program_counter,
        .service_exception, .service_interrupt);
    // Free-running 100 MHz clock.
    initial forever #5 clk = ~clk;
    // One guarded operation in slot s; issue stands for one cycle only.
    task issue_op(input integer s, input [7:0] o, input [31:0] a, input [31:0] b, input [6:0] n, input gl);
        begin
            @(posedge clk);
            issue[s] <= 1'b1;
            opcode[s*8+:8] <= o;
            first_source[s*32+:32] <= a;
            imm32[s*32+:32] <= a;
            second_source[s*32+:32] <= b;
            imm7[s*7+:7] <= n;
            guarded[s] <= 1'b1;
            guard_lsb[s] <= gl;
            dest_in[s*7+:7] <= ~n;
            @(posedge clk);
            issue <= 5'h00;
        end
    endtask
    // Compare or immediate, judged on the write port one cycle after issue.
    task cmp(input integer s, input [7:0] o, input [31:0] a, input [31:0] b, input [6:0] n, input gl,
        input en, input [31:0] ex);
        begin
            issue_op(s, o, a, b, n, gl);
            #1;
            `CHK(wr_en[s], en)
            if (en) `CHK(wr_data[s*32+:32], ex)
            `CHK(wr_dest[s*7+:7], ~n)
        end
    endtask
    // Jump on false; k is the expected {pc_load, exception, interrupt} pulse when it lands.
    task jmp(input integer s, input [31:0] c, input [31:0] t, input gl, input ex, input ir, input [2:0] k);
        begin
            @(posedge clk);
            exception_pending <= ex;
            interrupt_pending <= ir;
            issue_op(s, `GCIJ_OP_JMP_FALSE, c, t, 7'h00, gl);
            repeat (`GCIJ_JMP_DELAY) @(posedge clk);
            #1;
            if (k != 3'h0) exp_dpc = t;
            if (k == 3'h4) exp_pc = t;
            `CHK({pc_load, service_exception, service_interrupt}, k)
            `CHK({destination_program_counter, current_program_counter, restart_program_counter},
                {exp_dpc, exp_pc, exp_pc})
        end
    endtask
    // Verdict and end of run.
    task close_out;
        begin
            $display("checks %0d mismatches %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    // Watchdog far beyond the 84 cycles the sequence needs.
    initial begin
        #20000;
        failures++;
        close_out;
    end
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK({wr_en, pc_load, destination_program_counter}, 38'h0)
        cmp(0, `GCIJ_OP_GTR_IMM, 32'h3, 32'h0, 7'h02, 1'b1, 1'b1, 32'h1);
        cmp(1, `GCIJ_OP_GTR_IMM, 32'h3, 32'h0, 7'h03, 1'b1, 1'b1, 32'h0);
        cmp(2, `GCIJ_OP_GEQ_IMM, 32'h3, 32'h0, 7'h03, 1'b1, 1'b1, 32'h1);
        cmp(3, `GCIJ_OP_GEQ_IMM, 32'h3, 32'h0, 7'h04, 1'b1, 1'b1, 32'h0);
        cmp(4, `GCIJ_OP_GEQ_IMM, 32'h8000_0000, 32'h0, 7'h40, 1'b1, 1'b1, 32'h0);
        cmp(2, `GCIJ_OP_GEQ_IMM, 32'hffff_ffc0, 32'h0, 7'h40, 1'b1, 1'b1, 32'h1);
        cmp(0, `GCIJ_OP_GTR_IMM, 32'h100, 32'h0, 7'h3f, 1'b1, 1'b1, 32'h1);
        cmp(3, `GCIJ_OP_GTR, 32'h3, 32'h4, 7'h00, 1'b1, 1'b1, 32'h0);
        cmp(3, `GCIJ_OP_GTR, 32'h8000_0000, 32'h8000_0000, 7'h00, 1'b1, 1'b1, 32'h0);
        cmp(4, `GCIJ_OP_GTR, 32'h4, 32'h8000_0000, 7'h00, 1'b1, 1'b1, 32'h1);
        cmp(0, `GCIJ_OP_GTR_IMM, 32'h100, 32'h0, 7'h3f, 1'b0, 1'b0, 32'h0);
        cmp(1, `GCIJ_OP_IMM, 32'hfffc_0000, 32'h0, 7'h00, 1'b0, 1'b1, 32'hfffc_0000);
        jmp(1, 32'h0, 32'h330, 1'b1, 1'b0, 1'b0, 3'h4);
        jmp(3, 32'h1, 32'h8000, 1'b1, 1'b0, 1'b0, 3'h0);
        jmp(3, 32'h0, 32'h8000, 1'b0, 1'b0, 1'b0, 3'h0);
        jmp(2, 32'h0, 32'h8000, 1'b1, 1'b1, 1'b1, 3'h2);
        jmp(3, 32'h2, 32'h440, 1'b1, 1'b0, 1'b1, 3'h1);
        jmp(0, 32'h0, 32'h990, 1'b1, 1'b0, 1'b0, 3'h0);
        jmp(1, 32'h0, 32'h1234, 1'b1, 1'b0, 1'b0, 3'h4);
        jmp(4, 32'h0, 32'h550, 1'b1, 1'b0, 1'b0, 3'h0);
        close_out;
    end
endmodule

/* File: verilog/gcij_regs.vh */
`ifndef GCIJ_REGS_VH
`define GCIJ_REGS_VH
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define GCIJ_OP_GTR_IMM 8'h00
`define GCIJ_OP_GEQ_IMM 8'h01
`define GCIJ_OP_GTR 8'h0f
`define GCIJ_OP_IMM 8'hbf
`define GCIJ_OP_JMP_FALSE 8'hb5
// ----------------------------------------
// Slots and timing
// ----------------------------------------
`define GCIJ_SLOTS 5
`define GCIJ_JMP_SLOT_MIN 3'h2
`define GCIJ_JMP_SLOT_MAX 3'h4
`define GCIJ_JMP_DELAY 3
`define GCIJ_PC_RESET 32'h0000_0000
`endif

/* File: verilog/gcij_slot.v */
`timescale 1ns/10ps
// ----------------------------------------
// One issue slot: compare and immediate results
// ----------------------------------------
module gcij_slot (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Issue
    input wire issue,
    input wire [7:0] opcode,
    input wire [6:0] imm7,
    input wire [31:0] imm32,
    input wire guarded,
    input wire guard_lsb,
    input wire [31:0] first_source,
    input wire [31:0] second_source,
    input wire [6:0] dest_in,
    // Write-back
    output reg wr_en,
    output reg [6:0] wr_dest,
    output reg [31:0] wr_data
);
`include "gcij_regs.vh"

    // Signed greater-or-equal / greater, shared by all three compares.
    function cmp_ge;
        input [31:0] a;
        input [31:0] b;
        input strict;
        begin
            if (strict) begin
                cmp_ge = ($signed(a) > $signed(b)); // RULE_04
            end else begin
                cmp_ge = ($signed(a) >= $signed(b)); // RULE_04
            end
        end
    endfunction

    wire [31:0] imm_ext;
    reg next_en;
    reg [31:0] next_data;

    // Immediate is sign extended so -64..63 compares correctly.
    assign imm_ext = {{25{imm7[6]}}, imm7};

    // Decode; a false guard simply suppresses a compare's write; the immediate ignores it.
    always @* begin
        next_en = 1'b0;
        next_data = 32'h0000_0000;
        if (issue) begin
            if (opcode == `GCIJ_OP_GEQ_IMM) begin
                next_en = !guarded || guard_lsb; // RULE_05
                next_data = {31'h0000_0000, cmp_ge(first_source, imm_ext, 1'b0)}; // RULE_01
            end else if (opcode == `GCIJ_OP_GTR) begin
                next_en = !guarded || guard_lsb; // RULE_05
                next_data = {31'h0000_0000, cmp_ge(first_source, second_source, 1'b1)}; // RULE_02
            end else if (opcode == `GCIJ_OP_GTR_IMM) begin
                next_en = !guarded || guard_lsb; // RULE_05
                next_data = {31'h0000_0000, cmp_ge(first_source, imm_ext, 1'b1)}; // RULE_03
            end else if (opcode == `GCIJ_OP_IMM) begin
                next_en = 1'b1; // RULE_07
                next_data = imm32; // RULE_06
            end
        end
    end

    // Result one cycle after issue.
    always @(posedge clk) begin
        if (rst) begin
            wr_en <= 1'b0;
            wr_dest <= 7'h00;
            wr_data <= 32'h0000_0000;
        end else begin
            wr_en <= next_en; // RULE_12
            wr_dest <= dest_in;
            wr_data <= next_data;
        end
    end
endmodule

/* File: verilog/gcij_top.v */
`timescale 1ns/10ps
// Contract
// RULE_01: Greater-or-equal immediate writes 1 when source >= signed 7-bit immediate, else 0.
// RULE_02: Register greater-than writes 1 when first source strictly exceeds second.
// RULE_03: Greater-than immediate writes 1 only when source strictly exceeds immediate.
// RULE_04: All compares treat operands as signed 32-bit two's complement.
// RULE_05: A guarded compare writes only when guard bit 0 is 1.
// RULE_06: Signed immediate places its full 32-bit value into destination.
// RULE_07: Signed immediate is never guarded and always writes.
// RULE_08: Jump-on-false is taken only when condition bit 0 is 0.
// RULE_09: Taken with nothing pending loads destination, current and restart counters.
// RULE_10: Taken with pending event loads destination counter only; exception beats interrupt.
// RULE_11: False guard leaves all three counters untouched, condition ignored.
// RULE_12: Results one cycle after issue; jump acts after three delays, slots two to four.
module gcij_top (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Issue, one field per slot packed slot 1 in low bits
    input wire [4:0] issue,
    input wire [39:0] opcode,
    input wire [34:0] imm7,
    input wire [159:0] imm32,
    input wire [4:0] guarded,
    input wire [4:0] guard_lsb,
    input wire [159:0] first_source,
    input wire [159:0] second_source,
    input wire [34:0] dest_in,
    // Pending events from the sequencer
    input wire exception_pending,
    input wire interrupt_pending,
    // Write-back, per slot
    output wire [4:0] wr_en,
    output wire [34:0] wr_dest,
    output wire [159:0] wr_data,
    // Program counter updates
    output reg pc_load,
    output reg [31:0] current_program_counter,
    output reg [31:0] destination_program_counter,
    output reg [31:0] restart_program_counter,
    output reg service_exception,
    output reg service_interrupt
);
`include "gcij_regs.vh"

    // ----------------------------------------
    // Compare and immediate slots
    // ----------------------------------------
    genvar s;
    generate
        for (s = 0; s < `GCIJ_SLOTS; s = s + 1) begin : g_slot
            gcij_slot u_slot (
                .clk(clk),
                .rst(rst),
                .issue(issue[s]),
                .opcode(opcode[8*s+7 -: 8]),
                .imm7(imm7[7*s+6 -: 7]),
                .imm32(imm32[32*s+31 -: 32]),
                .guarded(guarded[s]),
                .guard_lsb(guard_lsb[s]),
                .first_source(first_source[32*s+31 -: 32]),
                .second_source(second_source[32*s+31 -: 32]),
                .dest_in(dest_in[7*s+6 -: 7]),
                .wr_en(wr_en[s]),
                .wr_dest(wr_dest[7*s+6 -: 7]),
                .wr_data(wr_data[32*s+31 -: 32])
            );
        end
    endgenerate

    // ----------------------------------------
    // Branch helper functions
    // ----------------------------------------

    // A guard, when present, lets the operation through only if its bit 0 is set.
    // Every branch slot uses this one function, so the slots cannot drift apart.
    function guard_ok;
        input is_guarded;
        input lsb;
        begin
            guard_ok = !is_guarded || lsb;
        end
    endfunction

    // The jump on false looks at bit 0 of its condition only; the upper bits are
    // ignored on purpose so that any compare result can feed it directly.
    function cond_false;
        input [31:0] cond;
        begin
            cond_false = !cond[0];
        end
    endfunction

    // True when a slot issues the jump-on-false opcode in this cycle.
    // Any other opcode in a branch slot belongs to another unit and is ignored here.
    function is_jump_op;
        input slot_issue;
        input [7:0] op;
        begin
            is_jump_op = slot_issue && (op == `GCIJ_OP_JMP_FALSE);
        end
    endfunction

    // ----------------------------------------
    // Branch slot fields
    // ----------------------------------------

    // Only slots two to four own a branch unit; slots one and five are never looked at
    // here, so a jump opcode placed there simply does nothing.
    wire issue_slot2;
    wire issue_slot3;
    wire issue_slot4;
    wire [7:0] op_slot2;
    wire [7:0] op_slot3;
    wire [7:0] op_slot4;
    wire guarded_slot2;
    wire guarded_slot3;
    wire guarded_slot4;
    wire guard_lsb_slot2;
    wire guard_lsb_slot3;
    wire guard_lsb_slot4;
    wire [31:0] cond_slot2;
    wire [31:0] cond_slot3;
    wire [31:0] cond_slot4;
    wire [31:0] target_slot2;
    wire [31:0] target_slot3;
    wire [31:0] target_slot4;

    // Slot two uses field index one.
    assign issue_slot2 = issue[1];
    assign op_slot2 = opcode[15:8];
    assign guarded_slot2 = guarded[1];
    assign guard_lsb_slot2 = guard_lsb[1];
    assign cond_slot2 = first_source[63:32];
    assign target_slot2 = second_source[63:32];

    // Slot three uses field index two.
    assign issue_slot3 = issue[2];
    assign op_slot3 = opcode[23:16];
    assign guarded_slot3 = guarded[2];
    assign guard_lsb_slot3 = guard_lsb[2];
    assign cond_slot3 = first_source[95:64];
    assign target_slot3 = second_source[95:64];

    // Slot four uses field index three.
    assign issue_slot4 = issue[3];
    assign op_slot4 = opcode[31:24];
    assign guarded_slot4 = guarded[3];
    assign guard_lsb_slot4 = guard_lsb[3];
    assign cond_slot4 = first_source[127:96];
    assign target_slot4 = second_source[127:96];

    // ----------------------------------------
    // Take decision per slot
    // ----------------------------------------

    // A slot takes its jump when it issues the opcode, its guard allows it and bit 0
    // of the condition source is clear. A false guard wins over any condition value.
    wire take_slot2;
    wire take_slot3;
    wire take_slot4;

    assign take_slot2 = is_jump_op(issue_slot2, op_slot2) // RULE_12
        && guard_ok(guarded_slot2, guard_lsb_slot2) // RULE_11
        && cond_false(cond_slot2); // RULE_08

    assign take_slot3 = is_jump_op(issue_slot3, op_slot3) // RULE_12
        && guard_ok(guarded_slot3, guard_lsb_slot3) // RULE_11
        && cond_false(cond_slot3); // RULE_08

    assign take_slot4 = is_jump_op(issue_slot4, op_slot4) // RULE_12
        && guard_ok(guarded_slot4, guard_lsb_slot4) // RULE_11
        && cond_false(cond_slot4); // RULE_08

    // ----------------------------------------
    // Slot priority
    // ----------------------------------------

    // The scheduler never puts two branches in one bundle. Should malformed code do
    // so anyway, the lowest slot wins and the others are dropped.
    reg jmp_take;
    reg [31:0] jmp_target;

    always @* begin
        jmp_take = 1'b0;
        jmp_target = 32'h0000_0000;
        if (take_slot2) begin
            jmp_take = 1'b1;
            jmp_target = target_slot2;
        end else if (take_slot3) begin
            jmp_take = 1'b1;
            jmp_target = target_slot3;
        end else if (take_slot4) begin
            jmp_take = 1'b1;
            jmp_target = target_slot4;
        end
    end

    // ----------------------------------------
    // Branch delay line
    // ----------------------------------------

    // One stage per delay instruction. The target travels with its valid bit so that
    // back-to-back jumps each land with their own target, in issue order.
    reg stage1_valid;
    reg stage2_valid;
    reg stage3_valid;
    reg [31:0] stage1_target;
    reg [31:0] stage2_target;
    reg [31:0] stage3_target;

    // Valid bits are cleared by reset so that no phantom redirect follows it.
    always @(posedge clk) begin
        if (rst) begin
            stage1_valid <= 1'b0;
            stage2_valid <= 1'b0;
            stage3_valid <= 1'b0;
        end else begin
            stage1_valid <= jmp_take; // RULE_12
            stage2_valid <= stage1_valid;
            stage3_valid <= stage2_valid;
        end
    end

    // Targets are only used together with their valid bit; they are zeroed anyway
    // to keep the counters free of unknown values after reset.
    always @(posedge clk) begin
        if (rst) begin
            stage1_target <= 32'h0000_0000;
            stage2_target <= 32'h0000_0000;
            stage3_target <= 32'h0000_0000;
        end else begin
            stage1_target <= jmp_target;
            stage2_target <= stage1_target;
            stage3_target <= stage2_target;
        end
    end

    // ----------------------------------------
    // Redirect and service request
    // ----------------------------------------

    // Next values for the counters and the single-cycle strobes.
    wire land;
    reg next_pc_load;
    reg next_service_exception;
    reg next_service_interrupt;
    reg [31:0] next_current_program_counter;
    reg [31:0] next_destination_program_counter;
    reg [31:0] next_restart_program_counter;

    // The redirect lands after the third delay instruction.
    assign land = stage3_valid;

    // Pending events are sampled when the redirect lands, not at issue, so an event
    // that arrives during the delay slots is still serviced on this jump.
    always @* begin
        next_pc_load = 1'b0;
        next_service_exception = 1'b0;
        next_service_interrupt = 1'b0;
        next_current_program_counter = current_program_counter;
        next_destination_program_counter = destination_program_counter;
        next_restart_program_counter = restart_program_counter;
        if (land) begin
            next_destination_program_counter = stage3_target; // RULE_10
            if (exception_pending) begin
                next_service_exception = 1'b1; // RULE_10
            end else if (interrupt_pending) begin
                next_service_interrupt = 1'b1; // RULE_10
            end else begin
                next_pc_load = 1'b1;
                next_current_program_counter = stage3_target; // RULE_09
                next_restart_program_counter = stage3_target; // RULE_09
            end
        end
    end

    // ----------------------------------------
    // Program counters and strobes
    // ----------------------------------------

    // The counters hold their value until the next jump lands.
    always @(posedge clk) begin
        if (rst) begin
            current_program_counter <= `GCIJ_PC_RESET;
            destination_program_counter <= `GCIJ_PC_RESET;
            restart_program_counter <= `GCIJ_PC_RESET;
        end else begin
            current_program_counter <= next_current_program_counter;
            destination_program_counter <= next_destination_program_counter;
            restart_program_counter <= next_restart_program_counter;
        end
    end

    // The load and service strobes are single-cycle pulses for the sequencer.
    always @(posedge clk) begin
        if (rst) begin
            pc_load <= 1'b0;
            service_exception <= 1'b0;
            service_interrupt <= 1'b0;
        end else begin
            pc_load <= next_pc_load; // RULE_09
            service_exception <= next_service_exception; // RULE_10
            service_interrupt <= next_service_interrupt; // RULE_10
        end
    end
endmodule
